/* inc/dps_pkg.sv */
// constants, types and the address map of the dual-port on-chip sram
// assumes addresses arrive already split into short, normal and long spaces
package dps_pkg;
    // storage geometry
    localparam int unsigned HW_BITS = 16;
    localparam int unsigned COLS    = 8;
    localparam int unsigned ROWS    = 4096;
    localparam int unsigned BLKS    = 2;
    localparam int unsigned PORTS   = 3;
    // port slots
    localparam int unsigned SLOT_PM = 0;
    localparam int unsigned SLOT_DM = 1;
    localparam int unsigned SLOT_IO = 2;
    // access width codes
    localparam logic [1:0] W16 = 2'h0;
    localparam logic [1:0] W32 = 2'h1;
    localparam logic [1:0] W48 = 2'h2;
    // address spaces: base, words per block, last internal address
    localparam logic [31:0] SHORT_BASE = 32'h0004_0000;
    localparam logic [31:0] SHORT_BLK  = 32'h0000_8000;
    localparam logic [31:0] SHORT_TOP  = 32'h0007_FFFF;
    localparam logic [31:0] NORM_BASE  = 32'h0002_0000;
    localparam logic [31:0] NORM_BLK   = 32'h0000_4000;
    localparam logic [31:0] NORM_TOP   = 32'h0003_FFFF;
    localparam logic [31:0] LONG_BASE  = 32'h0002_0000;
    localparam logic [31:0] LONG_BLK   = 32'h0000_2000;
    localparam logic [31:0] LONG_TOP   = 32'h0003_FFFF;
    // instruction cache default depth
    localparam int unsigned CACHE_DEPTH = 32;

    typedef enum logic [0:0] {
        FS_IDLE = 1'b0,
        FS_PEND = 1'b1
    } dps_fetch_e;

    typedef struct packed {
        logic        en;
        logic        we;
        logic [1:0]  width;
        logic [31:0] addr;
        logic [47:0] wdata;
    } dps_req_s;

    typedef struct packed {
        logic        hit;
        logic        blk;
        logic [14:0] idx;
        logic [1:0]  n;
    } dps_loc_s;
endpackage

/* rtl/dps_top.sv */
// dual-port on-chip sram: two blocks of 8x4k x16 columns, three ports, selective icache
// assumes requests are synchronous to clk_i; reads answer one cycle after the request
// Operation
// - one megabit as two independently addressed half-megabit blocks
// - each block eight 16-bit columns 4k deep; wide words span adjacent columns
// - core port and I/O port per block, single cycle, neither stalls other
// - two core transfers and one I/O transfer complete in one cycle
// - capacity 32k x32, 64k x16 or 16k x48, mixtures allowed
// - every location reachable as 16 or 32 bits, the lower three quarters of each block also as 48, chosen per access
// - data bus carries data only; program bus carries fetches and data
// - program and data buses serve the core together every cycle
// - cache allocates only fetches that collided with program-bus data
// - cache hit gives one instruction plus two operands in one cycle
// - an off-chip data-bus operand leaves the other transfers single cycle
// - block 0 at lowest internal address, block 1 contiguous after
// - addresses beyond block 1 alias onto block 1
`timescale 1ns/1ns
module dps_top #(
    parameter int unsigned CACHE_DEPTH = dps_pkg::CACHE_DEPTH
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // program memory bus: data access and instruction fetch
    input  wire dps_pkg::dps_req_s pm_req_i,
    input  wire logic              fetch_req_i,
    input  wire logic [31:0]       fetch_addr_i,
    output logic [47:0]            pm_rdata_o,
    output logic                   pm_ack_o,
    output logic                   pm_busy_o,
    output logic [47:0]            instr_o,
    output logic                   instr_valid_o,
    // data memory bus
    input  wire dps_pkg::dps_req_s dm_req_i,
    output logic [47:0]            dm_rdata_o,
    output logic                   dm_ack_o,
    // i/o processor and dma side
    input  wire dps_pkg::dps_req_s io_req_i,
    output logic [47:0]            io_rdata_o,
    output logic                   io_ack_o
);
    localparam int unsigned CIB = $clog2(CACHE_DEPTH);

    // address decode shared by all ports and the fetch path
    function automatic dps_pkg::dps_loc_s decode(input logic [1:0] w, input logic [31:0] a);
        dps_pkg::dps_loc_s l;
        logic [31:0]       base;
        logic [31:0]       bsz;
        logic [31:0]       top;
        logic [31:0]       off;
        logic [31:0]       sub;
        l = '0;
        base = dps_pkg::NORM_BASE;
        bsz = dps_pkg::NORM_BLK;
        top = dps_pkg::NORM_TOP;
        l.n = 2'h2;
        if (w == dps_pkg::W16) begin
            base = dps_pkg::SHORT_BASE;
            bsz = dps_pkg::SHORT_BLK;
            top = dps_pkg::SHORT_TOP;
            l.n = 2'h1;
        end else if (w == dps_pkg::W48) begin
            base = dps_pkg::LONG_BASE;
            bsz = dps_pkg::LONG_BLK;
            top = dps_pkg::LONG_TOP;
            l.n = 2'h3;
        end
        off = a - base;
        l.hit = (w != 2'h3) && (a >= base) && (a <= top);
        l.blk = (off >= bsz);
        sub = l.blk ? ((off - bsz) & (bsz - 32'h1)) : off;
        if (w == dps_pkg::W16) begin
            l.idx = sub[14:0];
        end else if (w == dps_pkg::W32) begin
            l.idx = {sub[13:0], 1'b0};
        end else begin
            l.idx = 15'(sub[12:0] * 3);
        end
        return l;
    endfunction

    // reset release through two flip-flops
    logic rst_s1_q;
    logic rst_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_q <= rst_s1_q;
        end
    end

    // storage: block, column, row
    logic [15:0]         mem [dps_pkg::BLKS][dps_pkg::COLS][dps_pkg::ROWS];
    dps_pkg::dps_fetch_e fs_q;
    logic [31:0]         pend_addr_q;
    logic [47:0]         cdat [CACHE_DEPTH];
    logic [31:0]         ctag [CACHE_DEPTH];
    logic [CACHE_DEPTH-1:0] cval_q;

    // fetch decode and cache lookup
    dps_pkg::dps_loc_s floc;
    logic [CIB-1:0]    fci;
    logic              chit;
    logic              pend;
    logic              collide;
    assign floc = decode(dps_pkg::W48, fetch_addr_i);
    assign fci = fetch_addr_i[CIB-1:0];
    assign chit = cval_q[fci] && (ctag[fci] == fetch_addr_i);
    assign pend = (fs_q == dps_pkg::FS_PEND);
    assign collide = fetch_req_i && floc.hit && pm_req_i.en && !pend;

    // program-bus slot: pending fetch, then data, then a plain fetch
    dps_pkg::dps_req_s req [dps_pkg::PORTS];
    dps_pkg::dps_loc_s loc [dps_pkg::PORTS];
    always_comb begin
        req[dps_pkg::SLOT_PM] = pm_req_i;
        if (pend) begin
            req[dps_pkg::SLOT_PM] = '{en: 1'b1, we: 1'b0, width: dps_pkg::W48, addr: pend_addr_q, wdata: '0};
        end else if (!pm_req_i.en) begin
            req[dps_pkg::SLOT_PM] = '{en: fetch_req_i, we: 1'b0, width: dps_pkg::W48, addr: fetch_addr_i, wdata: '0};
        end
        req[dps_pkg::SLOT_DM] = dm_req_i;
        req[dps_pkg::SLOT_IO] = io_req_i;
    end

    // read assembly from adjacent columns, old contents before this cycle's writes
    logic [47:0] rd [dps_pkg::PORTS];
    always_comb begin
        logic [14:0] i;
        i = '0;
        for (int p = 0; p < dps_pkg::PORTS; p++) begin
            loc[p] = decode(req[p].width, req[p].addr);
            rd[p] = '0;
            for (int k = 0; k < 3; k++) begin
                i = loc[p].idx + 15'(k);
                if (k < int'(loc[p].n)) begin
                    rd[p][16*k +: 16] = mem[loc[p].blk][i[2:0]][i[14:3]];
                end
            end
        end
    end

    // writes in slot order so the i/o side lands last and wins
    always_ff @(posedge clk_i) begin
        logic [14:0] j;
        j = '0;
        for (int p = 0; p < dps_pkg::PORTS; p++) begin
            for (int k = 0; k < 3; k++) begin
                j = loc[p].idx + 15'(k);
                if (req[p].en && req[p].we && loc[p].hit && (k < int'(loc[p].n))) begin
                    mem[loc[p].blk][j[2:0]][j[14:3]] <= req[p].wdata[16*k +: 16];
                end
            end
        end
    end

    // registered read data and acknowledges, all three ports each cycle
    always_ff @(posedge clk_i or negedge rst_q) begin
        if (!rst_q) begin
            pm_rdata_o <= '0;
            dm_rdata_o <= '0;
            io_rdata_o <= '0;
            pm_ack_o <= 1'b0;
            dm_ack_o <= 1'b0;
            io_ack_o <= 1'b0;
        end else begin
            pm_rdata_o <= rd[dps_pkg::SLOT_PM];
            dm_rdata_o <= rd[dps_pkg::SLOT_DM];
            io_rdata_o <= rd[dps_pkg::SLOT_IO];
            pm_ack_o <= pm_req_i.en && !pend && loc[dps_pkg::SLOT_PM].hit;
            dm_ack_o <= dm_req_i.en && loc[dps_pkg::SLOT_DM].hit;
            io_ack_o <= io_req_i.en && loc[dps_pkg::SLOT_IO].hit;
        end
    end

    // fetch state: a missed colliding fetch waits one cycle for the program bus
    always_ff @(posedge clk_i or negedge rst_q) begin
        if (!rst_q) begin
            fs_q <= dps_pkg::FS_IDLE;
            pm_busy_o <= 1'b0;
            pend_addr_q <= '0;
        end else begin
            fs_q <= (collide && !chit) ? dps_pkg::FS_PEND : dps_pkg::FS_IDLE;
            pm_busy_o <= collide && !chit;
            if (collide && !chit) begin
                pend_addr_q <= fetch_addr_i;
            end
        end
    end

    // instruction return: cache on a colliding hit, array otherwise
    always_ff @(posedge clk_i or negedge rst_q) begin
        if (!rst_q) begin
            instr_o <= '0;
            instr_valid_o <= 1'b0;
        end else begin
            instr_valid_o <= pend || (fetch_req_i && floc.hit && (!pm_req_i.en || chit));
            instr_o <= (collide && chit) ? cdat[fci] : rd[dps_pkg::SLOT_PM];
        end
    end

    // selective allocation, only the fetch that lost the program bus
    always_ff @(posedge clk_i or negedge rst_q) begin
        if (!rst_q) begin
            cval_q <= '0;
        end else if (pend) begin
            cval_q[pend_addr_q[CIB-1:0]] <= 1'b1;
        end
    end

    // cache payload, no reset needed behind the valid bits
    always_ff @(posedge clk_i) begin
        if (pend) begin
            cdat[pend_addr_q[CIB-1:0]] <= rd[dps_pkg::SLOT_PM];
            ctag[pend_addr_q[CIB-1:0]] <= pend_addr_q;
        end
    end

    // checks
    property p_single_cycle;
        @(posedge clk_i) disable iff (!rst_q)
        (io_req_i.en && loc[dps_pkg::SLOT_IO].hit) |=> io_ack_o;
    endproperty
    a_single_cycle: assert property (p_single_cycle) else $error("io access not answered in one cycle");

    property p_three_way;
        @(posedge clk_i) disable iff (!rst_q)
        (pm_req_i.en && !pend && loc[0].hit && dm_req_i.en && loc[1].hit && io_req_i.en && loc[2].hit)
        |=> (pm_ack_o && dm_ack_o && io_ack_o);
    endproperty
    a_three_way: assert property (p_three_way) else $error("concurrent transfers not all answered");

    property p_blk0_base;
        @(posedge clk_i) disable iff (!rst_q)
        (dm_req_i.addr == dps_pkg::NORM_BASE && dm_req_i.width == dps_pkg::W32)
        |-> (loc[1].hit && !loc[1].blk && loc[1].idx == 15'h0000);
    endproperty
    a_blk0_base: assert property (p_blk0_base) else $error("lowest address not block 0 row 0");

    property p_alias;
        @(posedge clk_i) disable iff (!rst_q)
        (dm_req_i.width == dps_pkg::W32 && dm_req_i.addr >= 32'h0002_8000 && dm_req_i.addr <= dps_pkg::NORM_TOP)
        |-> (loc[1].blk && loc[1].idx == {dm_req_i.addr[13:0], 1'b0});
    endproperty
    a_alias: assert property (p_alias) else $error("alias address misses block 1");

    property p_bad_width;
        @(posedge clk_i) disable iff (!rst_q)
        (io_req_i.en && io_req_i.width == 2'h3) |=> !io_ack_o;
    endproperty
    a_bad_width: assert property (p_bad_width) else $error("invalid width answered");

    property p_external;
        @(posedge clk_i) disable iff (!rst_q)
        (dm_req_i.en && !loc[1].hit && io_req_i.en && loc[2].hit) |=> (!dm_ack_o && io_ack_o);
    endproperty
    a_external: assert property (p_external) else $error("off-chip operand disturbed other port");

    property p_hit_fetch;
        @(posedge clk_i) disable iff (!rst_q)
        (collide && chit && loc[0].hit) |=> (instr_valid_o && pm_ack_o && !pm_busy_o && instr_o == $past(cdat[fci]));
    endproperty
    a_hit_fetch: assert property (p_hit_fetch) else $error("cache hit did not give fetch and data");

    property p_alloc_only_collide;
        @(posedge clk_i) disable iff (!rst_q)
        (pend) |-> $past(collide && !chit);
    endproperty
    a_alloc_only_collide: assert property (p_alloc_only_collide) else $error("allocation without collision");

    property p_miss_two_cycles;
        @(posedge clk_i) disable iff (!rst_q)
        (collide && !chit) |=> (pm_busy_o && !instr_valid_o) ##1 (instr_valid_o && !pm_busy_o);
    endproperty
    a_miss_two_cycles: assert property (p_miss_two_cycles) else $error("missed fetch not served next cycle");

    property p_io_wins;
        @(posedge clk_i) disable iff (!rst_q)
        (dm_req_i.en && dm_req_i.we && io_req_i.en && io_req_i.we && loc[2].hit && !pend
         && dm_req_i.addr == io_req_i.addr && dm_req_i.width == dps_pkg::W16 && io_req_i.width == dps_pkg::W16
         && pm_req_i.en && !pm_req_i.we && pm_req_i.addr == io_req_i.addr && pm_req_i.width == dps_pkg::W16)
        |=> (pm_rdata_o[15:0] == $past(rd[0][15:0]))
        ##0 (mem[$past(loc[2].blk)][$past(loc[2].idx[2:0])][$past(loc[2].idx[14:3])] == $past(io_req_i.wdata[15:0]));
    endproperty
    a_io_wins: assert property (p_io_wins) else $error("write collision not resolved to io");
endmodule

/* verification/dps_far_model.sv */
// far-side model: core program bus, core data bus and i/o requester
// assumes the bench stages requests, then calls go() once per clock cycle
`timescale 1ns/1ns
module dps_far_model (
    // clock
    input  wire logic         clk_i,
    // requests toward the memory
    output dps_pkg::dps_req_s pm_req_o,
    output dps_pkg::dps_req_s dm_req_o,
    output dps_pkg::dps_req_s io_req_o,
    output logic              fetch_req_o,
    output logic [31:0]       fetch_addr_o
);
    dps_pkg::dps_req_s st[3];
    logic              fst;
    logic [31:0]       fad;

    // all lanes idle at time zero
    initial begin
        pm_req_o = '0;
        dm_req_o = '0;
        io_req_o = '0;
        fetch_req_o = 1'b0;
        fetch_addr_o = '0;
        st = '{default: '0};
        fst = 1'b0;
        fad = '0;
    end

    // stage one request on slot s for the next go()
    task automatic put(input int s, input logic we, input logic [1:0] w, input logic [31:0] a, input logic [47:0] d);
        st[s] = '{1'b1, we, w, a, d};
    endtask

    // stage an instruction fetch
    task automatic fetch(input logic [31:0] a);
        fst = 1'b1;
        fad = a;
    endtask

    // drive staged lanes for one cycle; released lanes carry inverted stale values
    task automatic go();
        @(posedge clk_i);
        pm_req_o     <= st[0];
        dm_req_o     <= st[1];
        io_req_o     <= st[2];
        fetch_req_o  <= fst;
        fetch_addr_o <= fad;
        for (int i = 0; i < 3; i++) begin
            st[i].en    = 1'b0;
            st[i].addr  = ~st[i].addr;
            st[i].wdata = ~st[i].wdata;
        end
        fst = 1'b0;
        fad = ~fad;
    endtask
endmodule

/* verification/tb.sv */
// self-checking bench for the dual-port sram: widths, map, concurrency, cache
// assumes dps_top answers one cycle after a request is taken
`timescale 1ns/1ns
module tb;
    localparam logic [31:0] NB  = dps_pkg::NORM_BASE;
    localparam logic [31:0] NK  = dps_pkg::NORM_BLK;
    localparam logic [31:0] SB  = dps_pkg::SHORT_BASE;
    localparam logic [31:0] SK  = dps_pkg::SHORT_BLK;
    localparam logic [31:0] LB  = dps_pkg::LONG_BASE;
    logic              clk_i   = 1'b0;
    logic              rst_n_i = 1'b0;
    dps_pkg::dps_req_s pm_req, dm_req, io_req;
    logic              fetch_req, pm_ack, pm_busy, instr_valid, dm_ack, io_ack;
    logic [31:0]       fetch_addr;
    logic [47:0]       pm_rdata, dm_rdata, io_rdata, instr;
    int                n_mismatch = 0;
    int                cmp_count  = 0;
    int                cyc_n      = 0;

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    dps_far_model far (.clk_i(clk_i), .pm_req_o(pm_req), .dm_req_o(dm_req), .io_req_o(io_req),
        .fetch_req_o(fetch_req), .fetch_addr_o(fetch_addr));
    dps_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .pm_req_i(pm_req), .fetch_req_i(fetch_req),
        .fetch_addr_i(fetch_addr), .pm_rdata_o(pm_rdata), .pm_ack_o(pm_ack), .pm_busy_o(pm_busy),
        .instr_o(instr), .instr_valid_o(instr_valid), .dm_req_i(dm_req), .dm_rdata_o(dm_rdata),
        .dm_ack_o(dm_ack), .io_req_i(io_req), .io_rdata_o(io_rdata), .io_ack_o(io_ack));

    task automatic conclude();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk_d(input logic [47:0] g, input logic [47:0] e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_b(input logic g, input logic e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // one cycle, then let the edge's updates land before sampling
    task automatic cyc();
        far.go();
        #1;
    endtask

    // request edge plus answer edge
    task automatic run();
        cyc();
        cyc();
    endtask

    // one 48-bit word seen as two of its halfwords and as a 32-bit pair
    task automatic t_width();
        far.put(0, 1'b1, dps_pkg::W48, LB + 1, 48'hABCD_1234_5678);
        run();
        chk_b(pm_ack, 1'b1);
        far.put(0, 1'b0, dps_pkg::W16, SB + 5, 48'h0);
        far.put(1, 1'b0, dps_pkg::W16, SB + 3, 48'h0);
        far.put(2, 1'b0, dps_pkg::W32, NB + 2, 48'h0);
        run();
        chk_d(pm_rdata, 48'hABCD);
        chk_d(dm_rdata, 48'h5678);
        chk_d(io_rdata, 48'hABCD_1234);
    endtask

    // three writes in one cycle across the block boundary and block ends
    task automatic t_block();
        far.put(0, 1'b1, dps_pkg::W32, NB + NK - 1, 48'h1111_2222);
        far.put(1, 1'b1, dps_pkg::W32, NB + NK, 48'h3333_4444);
        far.put(2, 1'b1, dps_pkg::W32, NB + 2 * NK - 1, 48'h5555_6666);
        run();
        chk_b(pm_ack & dm_ack & io_ack, 1'b1);
        far.put(0, 1'b0, dps_pkg::W16, SB + SK - 1, 48'h0);
        far.put(1, 1'b0, dps_pkg::W16, SB + SK, 48'h0);
        far.put(2, 1'b0, dps_pkg::W16, SB + 2 * SK - 1, 48'h0);
        run();
        chk_d(pm_rdata, 48'h1111);
        chk_d(dm_rdata, 48'h4444);
        chk_d(io_rdata, 48'h5555);
    endtask

    // region past block 1 lands in block 1; lowest normal address is block 0 row 0
    task automatic t_alias();
        far.put(1, 1'b1, dps_pkg::W32, NB + 2 * NK + 7, 48'h7777_8888);
        run();
        far.put(1, 1'b1, dps_pkg::W32, NB, 48'h9999_AAAA);
        far.put(2, 1'b0, dps_pkg::W32, NB + NK + 7, 48'h0);
        run();
        chk_d(io_rdata, 48'h7777_8888);
        far.put(0, 1'b0, dps_pkg::W16, SB + 1, 48'h0);
        run();
        chk_d(pm_rdata, 48'h9999);
    endtask

    // same-location writes, then read beside a write
    task automatic t_wins();
        far.put(0, 1'b1, dps_pkg::W32, NB + 9, 48'hA);
        far.put(1, 1'b1, dps_pkg::W32, NB + 9, 48'hB);
        far.put(2, 1'b1, dps_pkg::W32, NB + 9, 48'hC);
        run();
        far.put(0, 1'b0, dps_pkg::W32, NB + 9, 48'h0);
        far.put(2, 1'b1, dps_pkg::W32, NB + 9, 48'hD);
        run();
        chk_d(pm_rdata, 48'hC);
        chk_b(io_ack, 1'b1);
        // halfword collision under a read: a dm win would leave 5 in the upper half
        far.put(0, 1'b0, dps_pkg::W16, SB + 19, 48'h0);
        far.put(1, 1'b1, dps_pkg::W16, SB + 19, 48'h5);
        far.put(2, 1'b1, dps_pkg::W16, SB + 19, 48'h0);
        run();
        chk_d(pm_rdata, 48'h0);
        // external address and bad width: neither acknowledged nor written
        far.put(0, 1'b1, dps_pkg::W32, 32'h0010_0000, 48'hE);
        far.put(2, 1'b1, 2'h3, NB + 9, 48'hF);
        run();
        chk_b(pm_ack | io_ack, 1'b0);
        // off-chip data operand beside an i/o read
        far.put(1, 1'b0, dps_pkg::W32, 32'h0010_0000, 48'h0);
        far.put(2, 1'b0, dps_pkg::W32, NB + 9, 48'h0);
        run();
        chk_b(dm_ack, 1'b0);
        chk_b(io_ack, 1'b1);
        chk_d(io_rdata, 48'hD);
    endtask

    // plain fetch, colliding miss, then colliding hit with two operands
    task automatic t_cache();
        far.put(2, 1'b1, dps_pkg::W48, LB + 4, 48'h1357_9BDF_2468);
        run();
        far.fetch(LB + 4);
        run();
        chk_b(instr_valid, 1'b1);
        chk_d(instr, 48'h1357_9BDF_2468);
        far.fetch(LB + 4);
        far.put(0, 1'b0, dps_pkg::W32, NB + 9, 48'h0);
        run();
        chk_b(pm_busy & ~instr_valid, 1'b1);
        chk_d(pm_rdata, 48'hD);
        cyc();
        chk_b(instr_valid & ~pm_busy, 1'b1);
        chk_d(instr, 48'h1357_9BDF_2468);
        // program bus on block 0, data bus on block 1
        far.fetch(LB + 4);
        far.put(0, 1'b0, dps_pkg::W32, NB + 9, 48'h0);
        far.put(1, 1'b0, dps_pkg::W32, NB + NK + 7, 48'h0);
        run();
        chk_b(instr_valid & pm_ack & dm_ack & ~pm_busy, 1'b1);
        chk_d(instr, 48'h1357_9BDF_2468);
        chk_d(pm_rdata, 48'hD);
        chk_d(dm_rdata, 48'h7777_8888);
    endtask

    // cycle ceiling well above the forty-odd cycles the run needs
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 2000) begin
            n_mismatch++;
            conclude();
        end
    end

    // reset, then the scenarios in turn
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_width();
        t_block();
        t_alias();
        t_wins();
        t_cache();
        conclude();
    end
endmodule
